// ==== core/fault_record_block_readout.sv ====
// Purpose: streams a stored fault record as a block read answer
// Assumes: a bus engine pulls bytes with valid/ready and frames the transfer itself
// Notes:   the first byte is the count, then 255 data bytes, the last flagged by o_last
//          the stores have no reset, so fill them before the first read
// Function
// - send count 0xff, then pointer snapshot byte
// - data bytes counted from zero, after count
// - bytes 55 to 237 replay loop history
// - byte 55 is entry at snapshot index
// - each later byte uses index one lower, 0 wrapping to 35
// - snapshot nine gives flags, temp high, low
// - fixed 36 entry layout, position 18 zero
// - snapshot holds write pointer at fault time
`timescale 1ns/1ns
`include "fault_record_params.svh"

module fault_record_block_readout (
    // clock and reset
    input  wire logic                      i_clk,
    input  wire logic                      i_arst_n,
    // fault capture
    input  wire logic                      i_fault_capture,
    input  wire logic [7:0]                i_log_ptr,
    // loop history store
    input  wire logic                      i_hist_wr,
    input  wire logic [5:0]                i_hist_addr,
    input  wire logic [7:0]                i_hist_data,
    // preamble store
    input  wire logic                      i_pre_wr,
    input  wire logic [5:0]                i_pre_addr,
    input  wire logic [7:0]                i_pre_data,
    // read stream
    input  wire logic                      i_start,
    input  wire logic                      i_ready,
    output logic                           o_valid,
    output fault_record_pkg::fr_byte_t     o_data,
    output logic                           o_last,
    output logic                           o_busy
);
    import fault_record_pkg::*;

    fr_state_t  state_r;
    fr_byte_t   snap_r;
    fr_byte_t   byte_nxt;
    logic [8:0] seq_r;
    logic [5:0] pos_r;
    logic [5:0] pos_nxt;
    logic [7:0] idx_nxt;
    logic       adv;
    logic       launch;
    logic       done;
    logic       step;
    fr_byte_t   hist_mem [`FR_LOOP_LEN];
    fr_byte_t   pre_mem  [`FR_PRE_LEN];

    ////////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic [5:0] pos_dec(input logic [5:0] p);
        if (p == 6'h00) begin
            return `FR_LOOP_MAX;
        end
        return p - 6'h01;
    endfunction

    function automatic logic in_loop(input logic [7:0] k);
        return (k >= `FR_LOOP_FIRST) && (k <= `FR_LOOP_LAST);
    endfunction

    function automatic fr_byte_t hist_byte(input logic [5:0] p);
        if (p > `FR_LOOP_MAX) begin
            return `FR_FILL_BYTE;
        end
        // slot 18 holds no reading, whatever was written there
        if (p == `FR_LOOP_ZERO_POS) begin
            return `FR_FILL_BYTE;
        end
        return hist_mem[p];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pointer snapshot
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            snap_r <= `FR_PTR_RESET;
        end else if (i_fault_capture) begin
            snap_r <= i_log_ptr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // record storage, layout slot 18 always reads zero
    always_ff @(posedge i_clk) begin
        if (i_hist_wr && (i_hist_addr <= `FR_LOOP_MAX)) begin
            if (i_hist_addr == `FR_LOOP_ZERO_POS) begin
                hist_mem[i_hist_addr] <= `FR_FILL_BYTE;
            end else begin
                hist_mem[i_hist_addr] <= i_hist_data;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_pre_wr && (i_pre_addr < 6'(`FR_PRE_LEN))) begin
            pre_mem[i_pre_addr] <= i_pre_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // next byte selection
    assign adv     = (state_r == ST_SEND) && i_ready;
    assign launch  = (state_r == ST_IDLE) && i_start;
    assign done    = adv && o_last;
    assign step    = adv && !o_last;
    assign idx_nxt = seq_r[7:0];

    always_comb begin
        byte_nxt = `FR_FILL_BYTE;
        pos_nxt  = pos_r;
        if (idx_nxt == `FR_PTR_BYTE) begin
            byte_nxt = snap_r;
        end else if (idx_nxt == `FR_RSVD_BYTE) begin
            byte_nxt = `FR_FILL_BYTE;
        end else if (idx_nxt < `FR_LOOP_FIRST) begin
            byte_nxt = pre_mem[idx_nxt[5:0]];
        end else if (in_loop(idx_nxt)) begin
            byte_nxt = hist_byte(pos_r);
            pos_nxt  = pos_dec(pos_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // transfer state
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (i_start) begin
                        state_r <= ST_SEND;
                    end
                end
                // a start while sending is dropped
                ST_SEND: begin
                    if (done) begin
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // table index of the byte loaded at the next take
    // stays at 255 after the final byte until the next start
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            seq_r <= 9'h000;
        end else if (launch) begin
            seq_r <= 9'h000;
        end else if (step) begin
            seq_r <= seq_r + 9'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // loop position, loaded from the snapshot at start
    // only the low six snapshot bits address the loop
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pos_r <= 6'h00;
        end else if (launch) begin
            pos_r <= snap_r[5:0];
        end else if (step) begin
            pos_r <= pos_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // byte offered to the sink, held until taken
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_valid <= 1'b0;
        end else if (launch) begin
            o_valid <= 1'b1;
        end else if (done) begin
            o_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // offered byte, the count first
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_data <= 8'h00;
        end else if (launch) begin
            o_data <= `FR_BYTE_COUNT;
        end else if (step) begin
            o_data <= byte_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // last flag rides with the final table byte
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_last <= 1'b0;
        end else if (launch) begin
            o_last <= 1'b0;
        end else if (done) begin
            o_last <= 1'b0;
        end else if (step) begin
            o_last <= (idx_nxt == `FR_LAST_BYTE);
        end
    end

    assign o_busy = (state_r == ST_SEND);

endmodule // fault_record_block_readout

// ==== core/fault_record_params.svh ====
// Purpose: constants for the fault record block readout
// Assumes: byte numbers are table indexes, so data byte k goes out k+1 bytes after the count
// Notes:   definitions only
`ifndef FAULT_RECORD_PARAMS_SVH
`define FAULT_RECORD_PARAMS_SVH

`define FR_BYTE_COUNT      8'hff
`define FR_PTR_BYTE        8'h00
`define FR_RSVD_BYTE       8'h01
`define FR_LOOP_FIRST      8'h37
`define FR_LOOP_LAST       8'hed
`define FR_LAST_BYTE       8'hfe
`define FR_LOOP_LEN        36
`define FR_LOOP_MAX        6'h23
`define FR_LOOP_ZERO_POS   6'h12
`define FR_PRE_LEN         55
`define FR_FILL_BYTE       8'h00
`define FR_PTR_RESET       8'h00

`endif

// ==== core/fault_record_pkg.sv ====
// Purpose: types for the fault record block readout
// Assumes: nothing
// Notes:   constants live in fault_record_params.svh
package fault_record_pkg;
    typedef enum logic {
        ST_IDLE,
        ST_SEND
    } fr_state_t;
    typedef logic [7:0] fr_byte_t;
endpackage

// ==== verification/fault_record_asserts.sv ====
// Purpose: checks the readout stream
// Assumes: snapshot not captured mid read
// Notes:   shadow history mirrors writes
`timescale 1ns/1ns
module fault_record_asserts (
    // clock and reset
    input  wire logic                       i_clk,
    input  wire logic                       i_arst_n,
    // fault capture and history writes
    input  wire logic                       i_fault_capture,
    input  wire logic [7:0]                 i_log_ptr,
    input  wire logic                       i_hist_wr,
    input  wire logic [5:0]                 i_hist_addr,
    input  wire logic [7:0]                 i_hist_data,
    // read stream
    input  wire logic                       i_start,
    input  wire logic                       i_ready,
    input  wire logic                       o_valid,
    input  wire fault_record_pkg::fr_byte_t o_data,
    input  wire logic                       o_last,
    input  wire logic                       o_busy
);
    logic [8:0] cnt_r;
    logic [7:0] snap_r;
    logic [5:0] idx_r;
    logic [7:0] hist_r [36];
    wire        take = o_valid && i_ready;
    wire        loop = o_valid && cnt_r > 9'h037 && cnt_r < 9'h0ef;
    always_ff @(posedge i_clk or negedge i_arst_n)
        if (!i_arst_n) snap_r <= 8'h00;
        else if (i_fault_capture) snap_r <= i_log_ptr;
    always_ff @(posedge i_clk or negedge i_arst_n)
        if (!i_arst_n) cnt_r <= 9'h000;
        else if (i_start && !o_busy) cnt_r <= 9'h000;
        else if (take) cnt_r <= cnt_r + 9'h001;
    always_ff @(posedge i_clk)
        if (take && cnt_r == 9'h037) idx_r <= snap_r[5:0];
        else if (take) idx_r <= (idx_r == 6'h00) ? 6'h23 : idx_r - 6'h01;
    always_ff @(posedge i_clk)
        if (i_hist_wr && i_hist_addr < 6'h24)
            hist_r[i_hist_addr] <= (i_hist_addr == 6'h12) ? 8'h00 : i_hist_data;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    sequence s_open; i_start && !o_busy; endsequence
    sequence s_final; take && o_last; endsequence
    AST_CNT: assert property (s_open |=> o_valid && o_data == 8'hff) else $error("count");
    AST_PTR: assert property (o_valid && cnt_r == 9'h001 |-> o_data == snap_r)
        else $error("ptr");
    AST_FIRST: assert property (o_valid && cnt_r == 9'h038 |->
        o_data == hist_r[snap_r[5:0]]) else $error("first");
    AST_STEP: assert property (take && cnt_r > 9'h037 && cnt_r < 9'h0ee |=>
        o_data == hist_r[idx_r]) else $error("step");
    AST_WRAP: assert property (loop && idx_r == 6'h23 |-> o_data == hist_r[35])
        else $error("wrap");
    AST_SLOT: assert property (loop && idx_r == 6'h12 |-> o_data == 8'h00) else $error("slot");
    AST_EX: assert property (o_valid && snap_r == 8'h09 && cnt_r == 9'h039 |->
        o_data == hist_r[8]) else $error("example");
    AST_TAIL: assert property (o_valid && cnt_r > 9'h0ee |->
        o_data == 8'h00 && o_last == (cnt_r == 9'h0ff)) else $error("tail");
    AST_BUSY: assert property (o_valid |-> o_busy) else $error("busy");
    AST_DONE: assert property (s_final |=> !o_valid && !o_busy) else $error("done");
endmodule // fault_record_asserts
bind fault_record_block_readout fault_record_asserts chk_u (.*);

// ==== verification/fault_record_block_readout_tb.sv ====
// Purpose: self checking bench for the readout
// Assumes: pointer captured while idle
// Notes:   expected bytes queued before start
`timescale 1ns/1ns
module fault_record_block_readout_tb;
    import fault_record_pkg::*;
    logic i_clk = 0, i_arst_n = 0, i_fault_capture = 0, i_hist_wr = 0, i_pre_wr = 0;
    logic i_start = 0, i_ready, stall = 0, o_valid, o_last, o_busy;
    logic [5:0] i_hist_addr = 0, i_pre_addr = 0;
    fr_byte_t i_log_ptr = 0, i_hist_data = 0, i_pre_data = 0, o_data, p, d, e;
    fr_byte_t hist[36], pre[55], exp_q[$];
    int n_fail = 0, checked = 0, cyc = 0;
    always #10 i_clk = ~i_clk;
    fault_record_block_readout dut_u (.*);
    stream_sink sink_u (.i_clk(i_clk), .i_stall(stall), .o_ready(i_ready));
    task automatic finish_test;
        if (n_fail == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(bit h, logic [5:0] a, fr_byte_t v);
        @(posedge i_clk) #1;
        if (h) {i_hist_wr, i_hist_addr, i_hist_data} = {1'b1, a, v};
        else {i_pre_wr, i_pre_addr, i_pre_data} = {1'b1, a, v};
        @(posedge i_clk) #1 {i_hist_wr, i_pre_wr} = 2'b00;
    endtask
    always @(posedge i_clk) begin
        if (o_valid === 1'b1 && i_ready === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            checked++;
            if (o_data !== e) begin
                n_fail++;
                $display("[FAIL] o_data exp %h got %h", e, o_data);
            end
            if (o_last !== (exp_q.size() == 0)) begin
                n_fail++;
                $display("[FAIL] o_last exp %b got %b", exp_q.size() == 0, o_last);
            end
        end else if (o_valid === 1'b1 && i_ready === 1'b1) begin
            checked++;
            n_fail++;
            $display("[FAIL] o_valid exp 0 got %b", o_valid);
        end
        if (++cyc == 4000) begin
            n_fail++;
            finish_test;
        end
    end
    initial begin
        void'($urandom(32'hbf37c644));
        repeat (10) @(posedge i_clk);
        #1 i_arst_n = 1;
        for (int k = 0; k < 36; k++) begin
            d = 8'($urandom);
            hist[k] = (k == 18) ? 8'h00 : d;
            wr(1, 6'(k), d);
        end
        for (int k = 2; k < 55; k++) begin
            d = 8'($urandom);
            pre[k] = d;
            wr(0, 6'(k), d);
        end
        for (int j = 0; j < 3; j++) begin
            p = j == 0 ? 8'h09 : (j == 1 ? 8'h00 : 8'h23);
            @(posedge i_clk) #1 {i_fault_capture, i_log_ptr} = {1'b1, p};
            @(posedge i_clk) #1 {i_fault_capture, stall, i_start} = {1'b0, j[0], 1'b1};
            exp_q = {8'hff, p, 8'h00};
            for (int k = 2; k < 55; k++) exp_q.push_back(pre[k]);
            for (int k = 55; k < 255; k++) begin
                d = (k > 237) ? 8'h00 : hist[(p - (k - 55) % 36 + 36) % 36];
                exp_q.push_back(d);
            end
            @(posedge i_clk) #1 i_start = 0;
            checked++;
            if (o_busy !== 1'b1) begin
                n_fail++;
                $display("[FAIL] o_busy exp 1 got %b", o_busy);
            end
            repeat (5) @(posedge i_clk);
            #1 i_start = 1;
            @(posedge i_clk) #1 i_start = 0;
            while (o_busy !== 1'b0) @(posedge i_clk);
            checked++;
            if (exp_q.size() != 0) begin
                n_fail++;
                $display("[FAIL] exp_q exp 0 got %0d", exp_q.size());
            end
            if (o_valid !== 1'b0) begin
                n_fail++;
                $display("[FAIL] o_valid exp 0 got %b", o_valid);
            end
        end
        finish_test;
    end
endmodule // fault_record_block_readout_tb

// ==== verification/stream_sink.sv ====
// Purpose: byte consumer on the far side
// Assumes: ready may stall at any cycle
// Notes:   takes whole bytes only
`timescale 1ns/1ns
module stream_sink (
    input  wire logic i_clk,
    input  wire logic i_stall,
    output logic      o_ready
);
    initial o_ready = 1'b0;
    always @(posedge i_clk) o_ready <= #1 i_stall ? 1'($urandom) : 1'b1;
endmodule // stream_sink
